// >>> src/fllc_pkg.sv
// constants, register map and carrier types for the loop configuration block
// Notes on behaviour
// - writing one to bit 15 copies pending multiplier values into the active loop.
// - while enabled, integer and numerator writes stay pending until the apply strobe.
// - fraction is a 16-bit numerator over a 16-bit denominator, plain integers.
// - main ratio bits 11:8 divide by code plus one.
// - main reference divider bits 7:6 divide by 1, 2, 4 or 8.
// - main source bits 3:0 pick master, bus, loop or interface clocks; others reserved.
// - main gain bits 5:2 give two to the code, saturating at 256.
// - synchroniser gain uses the same coding, saturating at 256.
// - synchroniser ratio bits 10:8 give 1, 2, 4, 8, and 16 for 1XX.
// - synchroniser reference divider bits 7:6 divide by 1, 2, 4 or 8.
// - synchroniser source follows the main source coding; others reserved.
// - synchroniser integer 10 bits, numerator and denominator 16 bits, reset zero.
// - oscillator equals sync ratio times 3 times sync input times multiplier.
// - with synchroniser enabled, denominator ignored, numerator scaled by 65536.
// - while disabled, integer and numerator writes take effect at once.
// - synchroniser bandwidth bit 0: 0 wide, 1 narrow, resets to 1.
`default_nettype none
package fllc_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] FLLC_IDX_ENABLE = 10'h171;
  localparam logic [9:0] FLLC_IDX_INTEGER = 10'h172;
  localparam logic [9:0] FLLC_IDX_NUM = 10'h173;
  localparam logic [9:0] FLLC_IDX_DEN = 10'h174;
  localparam logic [9:0] FLLC_IDX_RATIO = 10'h175;
  localparam logic [9:0] FLLC_IDX_REF = 10'h176;
  localparam logic [9:0] FLLC_IDX_GAIN = 10'h179;
  localparam logic [9:0] FLLC_IDX_S_ENABLE = 10'h181;
  localparam logic [9:0] FLLC_IDX_S_INTEGER = 10'h182;
  localparam logic [9:0] FLLC_IDX_S_NUM = 10'h183;
  localparam logic [9:0] FLLC_IDX_S_DEN = 10'h184;
  localparam logic [9:0] FLLC_IDX_S_RATIO = 10'h185;
  localparam logic [9:0] FLLC_IDX_S_REF = 10'h186;
  localparam logic [9:0] FLLC_IDX_S_GAIN = 10'h187;
  // field positions
  localparam int FLLC_APPLY_BIT = 15;
  localparam int FLLC_RATIO_LSB = 8;
  localparam int FLLC_DIV_LSB = 6;
  localparam int FLLC_GAIN_LSB = 2;
  // reset values
  localparam logic [9:0] FLLC_INTEGER_RST = 10'h008;
  localparam logic [15:0] FLLC_NUM_RST = 16'h0018;
  localparam logic [15:0] FLLC_DEN_RST = 16'h007D;
  localparam logic FLLC_BW_RST = 1'h1;
  // settings presented to the analog loop
  typedef struct packed {
    logic loop_enable;
    logic [9:0] integer_multiplier;
    logic [15:0] frac_numerator;
    logic [15:0] frac_denominator;
    logic frac_scaled;
    logic [4:0] ratio_factor;
    logic [3:0] ref_div_factor;
    logic [3:0] ref_source;
    logic ref_source_reserved;
    logic [8:0] gain_value;
  } fllc_main_cfg_t;
  typedef struct packed {
    logic sync_path_enable;
    logic [9:0] sync_integer_multiplier;
    logic [15:0] sync_frac_numerator;
    logic [15:0] sync_frac_denominator;
    logic [4:0] ratio_factor;
    logic [3:0] ref_div_factor;
    logic [3:0] ref_source;
    logic ref_source_reserved;
    logic [8:0] gain_value;
    logic bandwidth_narrow;
  } fllc_sync_cfg_t;
endpackage
`default_nettype wire

// >>> src/fllc_top.sv
// apb register bank and decoded settings for the first frequency-locked loop
//
// The APB slave port was left to the implementer.
`default_nettype none
module fllc_top #(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output fllc_pkg::fllc_main_cfg_t main_cfg,
  output fllc_pkg::fllc_sync_cfg_t sync_cfg
);
  import fllc_pkg::*;

  // raw register fields plus decoded outputs, all in one state word
  typedef struct packed {
    logic loop_enable;
    logic [9:0] pend_integer;
    logic [15:0] pend_numerator;
    logic [9:0] act_integer;
    logic [15:0] act_numerator;
    logic [15:0] frac_denominator;
    logic [3:0] main_ratio;
    logic [1:0] main_ref_divider;
    logic [3:0] main_ref_source;
    logic [3:0] main_gain;
    logic sync_path_enable;
    logic [9:0] sync_integer_multiplier;
    logic [15:0] sync_frac_numerator;
    logic [15:0] sync_frac_denominator;
    logic [2:0] sync_ratio;
    logic [1:0] sync_ref_divider;
    logic [3:0] sync_ref_source;
    logic [3:0] sync_gain;
    logic sync_bandwidth_select;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    fllc_main_cfg_t main_cfg;
    fllc_sync_cfg_t sync_cfg;
  } fllc_state_t;

  fllc_state_t st_r;
  fllc_state_t st_nxt;

  // gain code to multiplier, shared by both paths
  function automatic logic [8:0] fllc_gain(input logic [3:0] code);
    logic [8:0] g;
    g = 9'h100;
    if (!code[3]) begin
      g = 9'(9'h001 << code[2:0]);
    end
    return g;
  endfunction

  // reference divider code to division factor, shared by both paths
  function automatic logic [3:0] fllc_refdiv(input logic [1:0] code);
    logic [3:0] d;
    d = 4'(4'h1 << code);
    return d;
  endfunction

  // codes 0010 and 0111 have no clock behind them
  function automatic logic fllc_src_reserved(input logic [3:0] code);
    logic r;
    r = (code == 4'h2) || (code == 4'h7);
    return r;
  endfunction

  // merge the enabled byte lanes of a write over the old 16-bit value
  function automatic logic [15:0] fllc_merge(input logic [15:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [15:0] m;
    m = old;
    if (strb[0]) begin
      m[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      m[15:8] = wd[15:8];
    end
    return m;
  endfunction

  logic setup_phase;
  logic access_wr;
  logic [9:0] idx;
  logic addr_hit;
  logic [15:0] rd_word;
  logic [15:0] wv;
  logic apply_hit;

  // apb phase decode; registers are 16 bits in the low half of each word
  always_comb begin
    setup_phase = psel && !penable;
    access_wr = psel && penable && pwrite && st_r.pready && !st_r.pslverr;
    idx = paddr[11:2];
    addr_hit = 1'b0;
    rd_word = 16'h0000;
    case (idx)
      FLLC_IDX_ENABLE: begin
        addr_hit = 1'b1;
        rd_word = {15'h0000, st_r.loop_enable};
      end
      FLLC_IDX_INTEGER: begin
        addr_hit = 1'b1;
        rd_word = {6'h00, st_r.pend_integer}; // apply bit reads zero
      end
      FLLC_IDX_NUM: begin
        addr_hit = 1'b1;
        rd_word = st_r.pend_numerator;
      end
      FLLC_IDX_DEN: begin
        addr_hit = 1'b1;
        rd_word = st_r.frac_denominator;
      end
      FLLC_IDX_RATIO: begin
        addr_hit = 1'b1;
        rd_word = {4'h0, st_r.main_ratio, 8'h00};
      end
      FLLC_IDX_REF: begin
        addr_hit = 1'b1;
        rd_word = {8'h00, st_r.main_ref_divider, 2'h0, st_r.main_ref_source};
      end
      FLLC_IDX_GAIN: begin
        addr_hit = 1'b1;
        rd_word = {10'h000, st_r.main_gain, 2'h0};
      end
      FLLC_IDX_S_ENABLE: begin
        addr_hit = 1'b1;
        rd_word = {15'h0000, st_r.sync_path_enable};
      end
      FLLC_IDX_S_INTEGER: begin
        addr_hit = 1'b1;
        rd_word = {6'h00, st_r.sync_integer_multiplier};
      end
      FLLC_IDX_S_NUM: begin
        addr_hit = 1'b1;
        rd_word = st_r.sync_frac_numerator;
      end
      FLLC_IDX_S_DEN: begin
        addr_hit = 1'b1;
        rd_word = st_r.sync_frac_denominator;
      end
      FLLC_IDX_S_RATIO: begin
        addr_hit = 1'b1;
        rd_word = {5'h00, st_r.sync_ratio, 8'h00};
      end
      FLLC_IDX_S_REF: begin
        addr_hit = 1'b1;
        rd_word = {8'h00, st_r.sync_ref_divider, 2'h0, st_r.sync_ref_source};
      end
      FLLC_IDX_S_GAIN: begin
        addr_hit = 1'b1;
        rd_word = {10'h000, st_r.sync_gain, 1'b0, st_r.sync_bandwidth_select};
      end
      default: begin
        addr_hit = 1'b0;
        rd_word = 16'h0000;
      end
    endcase
    if (paddr[1:0] != 2'h0) begin
      addr_hit = 1'b0;
    end
  end

  // next state: bus answer, register writes, multiplier transfer and decode
  always_comb begin
    st_nxt = st_r;
    wv = 16'h0000;
    apply_hit = 1'b0;
    // answer one cycle after setup, so the access phase completes with no wait state
    st_nxt.pready = setup_phase;
    st_nxt.pslverr = setup_phase && !addr_hit;
    if (setup_phase) begin
      st_nxt.prdata = (!pwrite && addr_hit) ? {16'h0000, rd_word} : 32'h0000_0000;
    end
    if (access_wr) begin
      case (idx)
        FLLC_IDX_ENABLE: begin
          wv = fllc_merge({15'h0000, st_r.loop_enable}, pwdata, pstrb);
          st_nxt.loop_enable = wv[0]; // software enables last, after the rest
        end
        FLLC_IDX_INTEGER: begin
          wv = fllc_merge({6'h00, st_r.pend_integer}, pwdata, pstrb);
          st_nxt.pend_integer = wv[9:0]; // held pending while running
          apply_hit = pstrb[1] && pwdata[FLLC_APPLY_BIT]; // zero does nothing
        end
        FLLC_IDX_NUM: begin
          st_nxt.pend_numerator = fllc_merge(st_r.pend_numerator, pwdata, pstrb);
        end
        FLLC_IDX_DEN: begin
          st_nxt.frac_denominator = fllc_merge(st_r.frac_denominator, pwdata, pstrb);
        end
        FLLC_IDX_RATIO: begin
          wv = fllc_merge({4'h0, st_r.main_ratio, 8'h00}, pwdata, pstrb);
          st_nxt.main_ratio = wv[11:8];
        end
        FLLC_IDX_REF: begin
          wv = fllc_merge({8'h00, st_r.main_ref_divider, 2'h0, st_r.main_ref_source}, pwdata, pstrb);
          st_nxt.main_ref_divider = wv[7:6];
          st_nxt.main_ref_source = wv[3:0];
        end
        FLLC_IDX_GAIN: begin
          wv = fllc_merge({10'h000, st_r.main_gain, 2'h0}, pwdata, pstrb);
          st_nxt.main_gain = wv[5:2];
        end
        FLLC_IDX_S_ENABLE: begin
          wv = fllc_merge({15'h0000, st_r.sync_path_enable}, pwdata, pstrb);
          st_nxt.sync_path_enable = wv[0]; // set last by software
        end
        FLLC_IDX_S_INTEGER: begin
          wv = fllc_merge({6'h00, st_r.sync_integer_multiplier}, pwdata, pstrb);
          st_nxt.sync_integer_multiplier = wv[9:0];
        end
        FLLC_IDX_S_NUM: begin
          st_nxt.sync_frac_numerator = fllc_merge(st_r.sync_frac_numerator, pwdata, pstrb);
        end
        FLLC_IDX_S_DEN: begin
          st_nxt.sync_frac_denominator = fllc_merge(st_r.sync_frac_denominator, pwdata, pstrb);
        end
        FLLC_IDX_S_RATIO: begin
          wv = fllc_merge({5'h00, st_r.sync_ratio, 8'h00}, pwdata, pstrb);
          st_nxt.sync_ratio = wv[10:8];
        end
        FLLC_IDX_S_REF: begin
          wv = fllc_merge({8'h00, st_r.sync_ref_divider, 2'h0, st_r.sync_ref_source}, pwdata, pstrb);
          st_nxt.sync_ref_divider = wv[7:6];
          st_nxt.sync_ref_source = wv[3:0];
        end
        FLLC_IDX_S_GAIN: begin
          wv = fllc_merge({10'h000, st_r.sync_gain, 1'b0, st_r.sync_bandwidth_select}, pwdata, pstrb);
          st_nxt.sync_gain = wv[5:2];
          st_nxt.sync_bandwidth_select = wv[0];
        end
        default: begin
          wv = 16'h0000;
        end
      endcase
    end
    // integer and numerator move together so the loop never sees a half update
    if (!st_nxt.loop_enable) begin
      st_nxt.act_integer = st_nxt.pend_integer; // stopped loop follows writes directly
      st_nxt.act_numerator = st_nxt.pend_numerator;
    end else if (apply_hit) begin
      st_nxt.act_integer = st_nxt.pend_integer; // strobe copies pending values
      st_nxt.act_numerator = st_nxt.pend_numerator;
    end
    // main path settings as the oscillator sees them
    st_nxt.main_cfg.loop_enable = st_nxt.loop_enable;
    st_nxt.main_cfg.integer_multiplier = st_nxt.act_integer;
    st_nxt.main_cfg.frac_numerator = st_nxt.act_numerator;
    // with the synchroniser on, the numerator is a 1/65536 fraction and the denominator drops out
    st_nxt.main_cfg.frac_scaled = st_nxt.sync_path_enable;
    st_nxt.main_cfg.frac_denominator = st_nxt.sync_path_enable ? 16'h0000 : st_nxt.frac_denominator;
    st_nxt.main_cfg.ratio_factor = {1'b0, st_nxt.main_ratio} + 5'h01; // code plus one
    st_nxt.main_cfg.ref_div_factor = fllc_refdiv(st_nxt.main_ref_divider);
    st_nxt.main_cfg.ref_source = st_nxt.main_ref_source;
    st_nxt.main_cfg.ref_source_reserved = fllc_src_reserved(st_nxt.main_ref_source);
    st_nxt.main_cfg.gain_value = fllc_gain(st_nxt.main_gain);
    // synchroniser path; its ratio coding differs from the main one
    st_nxt.sync_cfg.sync_path_enable = st_nxt.sync_path_enable;
    st_nxt.sync_cfg.sync_integer_multiplier = st_nxt.sync_integer_multiplier;
    st_nxt.sync_cfg.sync_frac_numerator = st_nxt.sync_frac_numerator;
    st_nxt.sync_cfg.sync_frac_denominator = st_nxt.sync_frac_denominator;
    st_nxt.sync_cfg.ratio_factor = st_nxt.sync_ratio[2] ? 5'h10 : 5'(5'h01 << st_nxt.sync_ratio[1:0]);
    st_nxt.sync_cfg.ref_div_factor = fllc_refdiv(st_nxt.sync_ref_divider);
    st_nxt.sync_cfg.ref_source = st_nxt.sync_ref_source;
    st_nxt.sync_cfg.ref_source_reserved = fllc_src_reserved(st_nxt.sync_ref_source);
    st_nxt.sync_cfg.gain_value = fllc_gain(st_nxt.sync_gain);
    st_nxt.sync_cfg.bandwidth_narrow = st_nxt.sync_bandwidth_select;
  end

  // state register; reset loads documented defaults and their decoded forms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.pend_integer <= FLLC_INTEGER_RST;
      st_r.act_integer <= FLLC_INTEGER_RST;
      st_r.pend_numerator <= FLLC_NUM_RST;
      st_r.act_numerator <= FLLC_NUM_RST;
      st_r.frac_denominator <= FLLC_DEN_RST;
      st_r.sync_bandwidth_select <= FLLC_BW_RST;
      st_r.main_cfg.integer_multiplier <= FLLC_INTEGER_RST;
      st_r.main_cfg.frac_numerator <= FLLC_NUM_RST;
      st_r.main_cfg.frac_denominator <= FLLC_DEN_RST;
      st_r.main_cfg.ratio_factor <= 5'h01;
      st_r.main_cfg.ref_div_factor <= 4'h1;
      st_r.main_cfg.gain_value <= 9'h001;
      st_r.sync_cfg.ratio_factor <= 5'h01;
      st_r.sync_cfg.ref_div_factor <= 4'h1;
      st_r.sync_cfg.gain_value <= 9'h001;
      st_r.sync_cfg.bandwidth_narrow <= FLLC_BW_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign main_cfg = st_r.main_cfg;
  assign sync_cfg = st_r.sync_cfg;
endmodule
`default_nettype wire

// >>> sim/fllc_top_properties.sv
// concurrent checks on the ports of the loop configuration register bank
`default_nettype none
module fllc_top_properties
  import fllc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fllc_main_cfg_t main_cfg,
  input wire fllc_sync_cfg_t sync_cfg
);
  logic wr;
  logic [ADDR_W-3:0] ix;
  logic apply;
  // an accepted write, its register index, and a full apply request
  assign wr = psel && penable && pready && pwrite && !pslverr;
  assign ix = paddr[ADDR_W-1:2];
  // the apply bit sits in lane 1, so lane 1 alone is enough to fire it
  assign apply = wr && ix == FLLC_IDX_INTEGER && pwdata[15] && pstrb[1];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready; psel && !penable |=> pready ##1 !pready; endproperty
  a_ready: assert property (p_ready) else $error("answer not exactly one cycle after setup");
  property p_ratio; wr && ix == FLLC_IDX_RATIO && pstrb[1] |=>
    main_cfg.ratio_factor == {1'b0, $past(pwdata[11:8])} + 5'd1; endproperty
  a_ratio: assert property (p_ratio) else $error("main ratio decode wrong");
  property p_div; wr && ix == FLLC_IDX_REF && pstrb[0] |=>
    main_cfg.ref_div_factor == 4'd1 << $past(pwdata[7:6]); endproperty
  a_div: assert property (p_div) else $error("main divider decode wrong");
  property p_rsv; wr && ix == FLLC_IDX_REF && pstrb[0] |=>
    main_cfg.ref_source_reserved == ($past(pwdata[3:0]) inside {4'h2, 4'h7}); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source flag wrong");
  property p_gain; wr && ix == FLLC_IDX_GAIN && pstrb[0] |=>
    main_cfg.gain_value == ($past(pwdata[5]) ? 9'd256 : 9'd1 << $past(pwdata[4:2])); endproperty
  a_gain: assert property (p_gain) else $error("main gain decode wrong");
  property p_sratio; wr && ix == FLLC_IDX_S_RATIO && pstrb[1] |=>
    sync_cfg.ratio_factor == ($past(pwdata[10]) ? 5'd16 : 5'd1 << $past(pwdata[9:8])); endproperty
  a_sratio: assert property (p_sratio) else $error("sync ratio decode wrong");
  // a running loop keeps its active multiplier unless applied or stopped
  property p_hold; main_cfg.loop_enable && !apply && !(wr && ix == FLLC_IDX_ENABLE) |=>
    $stable(main_cfg.integer_multiplier) && $stable(main_cfg.frac_numerator); endproperty
  a_hold: assert property (p_hold) else $error("active multiplier moved without apply");
  property p_apply; main_cfg.loop_enable && apply && pstrb[0] |=>
    main_cfg.integer_multiplier == $past(pwdata[9:0]); endproperty
  a_apply: assert property (p_apply) else $error("apply did not load integer");
  property p_direct; !main_cfg.loop_enable && wr && ix == FLLC_IDX_NUM && pstrb[1:0] == 2'b11 |=>
    main_cfg.frac_numerator == $past(pwdata[15:0]); endproperty
  a_direct: assert property (p_direct) else $error("idle numerator write not direct");
  property p_rdz; psel && penable && pready && !pwrite && ix == FLLC_IDX_INTEGER |->
    prdata[15] == 1'b0 && prdata[31:16] == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("apply bit read back set");
  property p_scaled; sync_cfg.sync_path_enable |->
    main_cfg.frac_scaled && main_cfg.frac_denominator == 16'h0000; endproperty
  a_scaled: assert property (p_scaled) else $error("denominator used while synchronised");
  property p_bw; wr && ix == FLLC_IDX_S_GAIN && pstrb[0] |=>
    sync_cfg.bandwidth_narrow == $past(pwdata[0]); endproperty
  a_bw: assert property (p_bw) else $error("bandwidth bit not taken");
  // main scenarios reached
  c_apply: cover property (main_cfg.loop_enable && apply);
  c_sync: cover property (sync_cfg.sync_path_enable && main_cfg.loop_enable);
  c_err: cover property (pready && pslverr);
endmodule
bind fllc_top fllc_top_properties #(.ADDR_W(ADDR_W)) fllc_top_properties_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .main_cfg(main_cfg), .sync_cfg(sync_cfg));
`default_nettype wire

// >>> sim/fllc_tb_top.sv
// self-checking bench for the loop configuration register bank
`default_nettype none
module fllc_tb_top
  import fllc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  fllc_main_cfg_t main_cfg;
  fllc_sync_cfg_t sync_cfg;
  int fail_count, tests_run;
  logic [15:0] r [14];
  logic [9:0] aint;
  logic [15:0] anum;
  localparam logic [9:0] IX [14] = '{FLLC_IDX_ENABLE, FLLC_IDX_INTEGER, FLLC_IDX_NUM, FLLC_IDX_DEN,
    FLLC_IDX_RATIO, FLLC_IDX_REF, FLLC_IDX_GAIN, FLLC_IDX_S_ENABLE, FLLC_IDX_S_INTEGER, FLLC_IDX_S_NUM,
    FLLC_IDX_S_DEN, FLLC_IDX_S_RATIO, FLLC_IDX_S_REF, FLLC_IDX_S_GAIN};
  // writable bits per register; the apply bit is left out because it reads as zero
  localparam logic [15:0] MK [14] = '{16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0F00, 16'h00CF,
    16'h003C, 16'h0001, 16'h03FF, 16'hFFFF, 16'hFFFF, 16'h0700, 16'h00CF, 16'h003D};
  localparam logic [15:0] RV [14] = '{16'h0000, {6'h00, FLLC_INTEGER_RST}, FLLC_NUM_RST, FLLC_DEN_RST,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0001};

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  fllc_top #(.ADDR_W(12)) fllc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .main_cfg(main_cfg), .sync_cfg(sync_cfg));

  function automatic logic [11:0] ba(logic [9:0] i);
    return {i, 2'b00};
  endfunction

  // power-of-two gain saturating at the top code range
  function automatic logic [8:0] gdec(logic [3:0] c);
    return c[3] ? 9'd256 : 9'd1 << c[2:0];
  endfunction

  function automatic int slot(logic [11:0] a);
    slot = -1;
    for (int i = 0; i < 14; i++) if (a[1:0] == 2'b00 && a[11:2] == IX[i]) slot = i;
  endfunction

  function automatic fllc_main_cfg_t exp_main();
    fllc_main_cfg_t e;
    e.loop_enable = r[0][0];
    e.integer_multiplier = aint;
    e.frac_numerator = anum;
    e.frac_denominator = r[7][0] ? 16'h0000 : r[3];
    e.frac_scaled = r[7][0];
    e.ratio_factor = {1'b0, r[4][11:8]} + 5'd1;
    e.ref_div_factor = 4'd1 << r[5][7:6];
    e.ref_source = r[5][3:0];
    e.ref_source_reserved = r[5][3:0] inside {4'h2, 4'h7};
    e.gain_value = gdec(r[6][5:2]);
    return e;
  endfunction

  function automatic fllc_sync_cfg_t exp_sync();
    fllc_sync_cfg_t e;
    e.sync_path_enable = r[7][0];
    e.sync_integer_multiplier = r[8][9:0];
    e.sync_frac_numerator = r[9];
    e.sync_frac_denominator = r[10];
    e.ratio_factor = r[11][10] ? 5'd16 : 5'd1 << r[11][9:8];
    e.ref_div_factor = 4'd1 << r[12][7:6];
    e.ref_source = r[12][3:0];
    e.ref_source_reserved = r[12][3:0] inside {4'h2, 4'h7};
    e.gain_value = gdec(r[13][5:2]);
    e.bandwidth_narrow = r[13][0];
    return e;
  endfunction

  task automatic chk(string nm, logic [127:0] e, logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, model update and comparison of every result
  task automatic xfer(logic [11:0] a, bit w, logic [15:0] d, logic [3:0] s);
    int k;
    logic [15:0] bm;
    logic [31:0] rd;
    logic er;
    k = slot(a);
    bm = {{8{s[1]}}, {8{s[0]}}};
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'($urandom), d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pslverr", k < 0, er);
    if (!w) chk("prdata", (k < 0) ? 16'h0000 : r[k], rd);
    if (w && k >= 0) begin
      r[k] = (r[k] & ~(MK[k] & bm)) | (d & MK[k] & bm);
      // idle loop follows writes; a running one only on a full apply
      if (!r[0][0] || (k == 1 && d[15] && s[1])) begin
        aint = r[1][9:0];
        anum = r[2];
      end
    end
    @(negedge pclk);
    chk("main_cfg", exp_main(), main_cfg);
    chk("sync_cfg", exp_sync(), sync_cfg);
  endtask

  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 14; i++) r[i] = RV[i];
    aint = FLLC_INTEGER_RST;
    anum = FLLC_NUM_RST;
    @(negedge pclk);
    chk("main_cfg", exp_main(), main_cfg);
    chk("sync_cfg", exp_sync(), sync_cfg);
    for (int i = 0; i < 14; i++) xfer(ba(IX[i]), 1'b0, 16'h0000, 4'hF);
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    int k;
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    fail_count = 0;
    tests_run = 0;
    void'($urandom(32'hE337));
    do_reset();
    // every code of each decoded field, bandwidth included, loop idle; synchroniser gain sees only nine of its codes
    for (int c = 0; c < 16; c++) begin
      xfer(ba(FLLC_IDX_RATIO), 1'b1, 16'(c << 8), 4'hF);
      xfer(ba(FLLC_IDX_REF), 1'b1, 16'((c << 6) | c), 4'hF);
      xfer(ba(FLLC_IDX_GAIN), 1'b1, 16'(c << 2), 4'hF);
      xfer(ba(FLLC_IDX_S_RATIO), 1'b1, 16'(c << 8), 4'hF);
      xfer(ba(FLLC_IDX_S_REF), 1'b1, 16'((c << 6) | c), 4'hF);
      xfer(ba(FLLC_IDX_S_GAIN), 1'b1, 16'((c << 2) | c), 4'hF);
    end
    // running loop: pending values wait for a full apply
    xfer(ba(FLLC_IDX_NUM), 1'b1, 16'h1234, 4'hF);
    xfer(ba(FLLC_IDX_INTEGER), 1'b1, 16'h0123, 4'hF);
    // prime denominator keeps both numerators below it and co-prime
    xfer(ba(FLLC_IDX_DEN), 1'b1, 16'hFFF1, 4'hF);
    xfer(ba(FLLC_IDX_ENABLE), 1'b1, 16'h0001, 4'hF);
    xfer(ba(FLLC_IDX_INTEGER), 1'b1, 16'h0055, 4'hF);
    xfer(ba(FLLC_IDX_NUM), 1'b1, 16'h4321, 4'hF);
    xfer(ba(FLLC_IDX_INTEGER), 1'b1, 16'h8066, 4'h1);
    xfer(ba(FLLC_IDX_INTEGER), 1'b0, 16'h0000, 4'hF);
    xfer(ba(FLLC_IDX_INTEGER), 1'b1, 16'h83FF, 4'hF);
    xfer(ba(FLLC_IDX_INTEGER), 1'b1, 16'h0001, 4'hF);
    xfer(ba(FLLC_IDX_ENABLE), 1'b1, 16'h0000, 4'hF);
    // synchroniser fields first, enable last, main denominator then ignored
    xfer(ba(FLLC_IDX_S_INTEGER), 1'b1, 16'h0155, 4'hF);
    xfer(ba(FLLC_IDX_S_NUM), 1'b1, 16'h8000, 4'hF);
    // fast reference: ratio 1, gain 16, wide bandwidth, halved to stay in range
    xfer(ba(FLLC_IDX_S_RATIO), 1'b1, 16'h0000, 4'hF);
    xfer(ba(FLLC_IDX_S_GAIN), 1'b1, 16'h0010, 4'hF);
    xfer(ba(FLLC_IDX_S_REF), 1'b1, 16'h0040, 4'hF);
    xfer(ba(FLLC_IDX_S_ENABLE), 1'b1, 16'h0001, 4'hF);
    // refused: gap in the map, misaligned, far outside
    xfer(ba(10'h177), 1'b1, 16'hFFFF, 4'hF);
    xfer(ba(FLLC_IDX_NUM) | 12'h002, 1'b1, 16'hAAAA, 4'hF);
    xfer(12'hFFC, 1'b0, 16'h0000, 4'hF);
    // random traffic over the whole map, lanes and apply included
    repeat (300) begin
      k = $urandom_range(13);
      xfer(ba(IX[k]), 1'($urandom_range(1)), 16'($urandom), 4'($urandom));
    end
    do_reset();
    results();
  end

  // watchdog sized well above the roughly fourteen hundred cycles the sequence needs
  initial begin
    #400000;
    fail_count++;
    $display("Error watchdog expected finish seen hang");
    results();
  end
endmodule
`default_nettype wire
